// ---- hdl/smcp_top.sv ----
// Purpose: Monitor-mode front end of the first serial port
// Assumes: External UART delivers rx bytes and takes tx bytes with a handshake
// Notes: Job execution is delegated; this block frames echo, errors and prompt
`timescale 1ns/100ps
module smcp_top #(
  parameter int DEPTH = smcp_pkg::RX_DEPTH,
  parameter int MARGIN = smcp_pkg::RX_MARGIN
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Mode selection
  input wire logic run_sel,
  input wire logic [1:0] serial_mode_constant,
  input wire logic mode_strap_pin,
  output logic active_mode,
  // Program cycle
  input wire logic cycle_running,
  output logic mode_strap_pin_suspend,
  // Serial line handshake
  output logic rts,
  input wire logic cts,
  // Receive bytes from UART
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Transmit bytes to UART
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Job executor
  output logic job_char_valid,
  output logic [7:0] job_char,
  output logic job_start,
  input wire logic job_done,
  input wire logic job_error,
  input wire logic job_host_display,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  output logic job_abort,
  input wire logic [7:0] err_valid_len,
  input wire logic [7:0] err_data,
  output logic err_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int THRESH = DEPTH - MARGIN;
  function automatic logic is_swflow(input logic [7:0] b);
    return (b == smcp_pkg::CHR_XON) || (b == smcp_pkg::CHR_XOFF);
  endfunction

  // Mode decision
  always_comb begin
    if (!run_sel) begin
      active_mode = 1'b1;
    end else if (serial_mode_constant == smcp_pkg::SERIAL_MODE_ACTIVE) begin
      active_mode = 1'b1;
    end else if (serial_mode_constant == smcp_pkg::SERIAL_MODE_STRAP) begin
      active_mode = mode_strap_pin;
    end else begin
      active_mode = 1'b0;
    end
  end

  // Receive buffer pointers
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] fill;
  logic is_flow, is_ctrl_c, store;
  logic xoff_q, xoff_d, abort_q, abort_d;
  logic [7:0] rd_byte;
  assign fill = wp_q - rp_q;
  assign is_flow = is_swflow(rx_data);
  assign is_ctrl_c = (rx_data == smcp_pkg::CHR_CTRL_C);
  assign store = rx_valid && active_mode && !is_flow && !is_ctrl_c
                 && (fill != (AW+1)'(DEPTH));
  assign mode_strap_pin_suspend = rx_valid && cycle_running;
  assign rts = active_mode && !cycle_running && (fill < (AW+1)'(THRESH));

  smcp_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .wr_en(store),
    .wr_addr(wp_q[AW-1:0]),
    .wr_data(rx_data),
    .rd_addr(rp_q[AW-1:0]),
    .rd_data_q(rd_byte)
  );

  // Controller state
  smcp_pkg::smcp_state_t st_q, st_d;
  logic rd_wait_q, rd_wait_d;
  logic [7:0] hold_q, hold_d;
  logic gap, can_tx;
  assign gap = !cycle_running;
  assign can_tx = gap && cts && !xoff_q && tx_ready;

  always_comb begin
    st_d = st_q;
    rp_d = rp_q;
    wp_d = store ? wp_q + 1'b1 : wp_q;
    xoff_d = xoff_q;
    abort_d = 1'b0;
    rd_wait_d = 1'b0;
    hold_d = hold_q;
    tx_valid = 1'b0;
    tx_data = hold_q;
    job_char_valid = 1'b0;
    job_start = 1'b0;
    out_ready = 1'b0;
    err_ready = 1'b0;
    if (rx_valid && rx_data == smcp_pkg::CHR_XOFF) begin
      xoff_d = 1'b1;
    end else if (rx_valid && rx_data == smcp_pkg::CHR_XON) begin
      xoff_d = 1'b0;
    end
    case (st_q)
      smcp_pkg::SMCP_IDLE: begin
        if (gap && fill != '0 && !rd_wait_q) begin
          rd_wait_d = 1'b1;
          st_d = smcp_pkg::SMCP_ECHO;
        end
      end
      smcp_pkg::SMCP_ECHO: begin
        hold_d = rd_byte;
        tx_data = rd_byte;
        if (can_tx) begin
          tx_valid = 1'b1;
          job_char_valid = 1'b1;
          rp_d = rp_q + 1'b1;
          if (rd_byte == smcp_pkg::CHR_CR) begin
            job_start = 1'b1;
            st_d = smcp_pkg::SMCP_EXEC;
          end else begin
            st_d = smcp_pkg::SMCP_IDLE;
          end
        end
      end
      smcp_pkg::SMCP_EXEC: begin
        if (job_error) begin
          tx_data = smcp_pkg::CHR_HASH;
          if (can_tx) begin
            tx_valid = 1'b1;
            st_d = smcp_pkg::SMCP_ERR;
          end
        end else if (job_done) begin
          st_d = smcp_pkg::SMCP_CR;
        end else if (out_valid) begin
          st_d = smcp_pkg::SMCP_OUT;
        end
      end
      smcp_pkg::SMCP_OUT: begin
        tx_data = out_data;
        if ((job_host_display && out_data == smcp_pkg::CHR_ESC) || is_swflow(out_data)) begin
          out_ready = 1'b1;
          st_d = smcp_pkg::SMCP_EXEC;
        end else if (can_tx) begin
          tx_valid = 1'b1;
          out_ready = 1'b1;
          st_d = smcp_pkg::SMCP_EXEC;
        end
      end
      smcp_pkg::SMCP_ERR: begin
        tx_data = err_data;
        if (err_valid_len == 8'h00) begin
          st_d = smcp_pkg::SMCP_CR;
        end else if (is_swflow(err_data)) begin
          err_ready = 1'b1;
        end else if (can_tx) begin
          tx_valid = 1'b1;
          err_ready = 1'b1;
        end
      end
      smcp_pkg::SMCP_CR: begin
        tx_data = smcp_pkg::CHR_CR;
        if (can_tx) begin
          tx_valid = 1'b1;
          st_d = smcp_pkg::SMCP_LF;
        end
      end
      smcp_pkg::SMCP_LF: begin
        tx_data = smcp_pkg::CHR_LF;
        if (can_tx) begin
          tx_valid = 1'b1;
          st_d = smcp_pkg::SMCP_GT;
        end
      end
      smcp_pkg::SMCP_GT: begin
        tx_data = smcp_pkg::CHR_PROMPT;
        if (can_tx) begin
          tx_valid = 1'b1;
          st_d = smcp_pkg::SMCP_IDLE;
        end
      end
      default: st_d = smcp_pkg::SMCP_IDLE;
    endcase
    if (rx_valid && is_ctrl_c && active_mode && (st_q == smcp_pkg::SMCP_EXEC
        || st_q == smcp_pkg::SMCP_OUT || st_q == smcp_pkg::SMCP_ERR)) begin
      abort_d = 1'b1;
      st_d = smcp_pkg::SMCP_CR;
    end
  end

  assign job_char = hold_d;
  assign job_abort = abort_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= smcp_pkg::SMCP_IDLE;
      wp_q <= '0;
      rp_q <= '0;
      xoff_q <= 1'b0;
      abort_q <= 1'b0;
      rd_wait_q <= 1'b0;
      hold_q <= 8'h00;
    end else begin
      st_q <= st_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      xoff_q <= xoff_d;
      abort_q <= abort_d;
      rd_wait_q <= rd_wait_d;
      hold_q <= hold_d;
    end
  end

  // Checks
  sequence s_prompt;
    tx_valid && tx_data == smcp_pkg::CHR_CR ##[1:1000] tx_valid && tx_data == smcp_pkg::CHR_LF;
  endsequence
  AST_MODE_STOP: assert property (@(posedge sys_clk) disable iff (reset)
    !run_sel |-> active_mode) else $error("stop not active");
  AST_MODE_ONE: assert property (@(posedge sys_clk) disable iff (reset)
    run_sel && serial_mode_constant == smcp_pkg::SERIAL_MODE_ACTIVE |-> active_mode)
    else $error("mode one");
  AST_MODE_STRAP: assert property (@(posedge sys_clk) disable iff (reset)
    run_sel && serial_mode_constant == smcp_pkg::SERIAL_MODE_STRAP |->
    active_mode == mode_strap_pin) else $error("strap mode");
  AST_RTS_CYCLE: assert property (@(posedge sys_clk) disable iff (reset)
    cycle_running || fill >= (AW+1)'(THRESH) |-> !rts) else $error("rts high");
  AST_TX_GAP: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid |-> !cycle_running && cts && !xoff_q) else $error("tx blocked");
  AST_NO_SWFLOW: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid |-> !is_swflow(tx_data)) else $error("sent flow char");
  AST_PROMPT: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && tx_data == smcp_pkg::CHR_CR && st_q == smcp_pkg::SMCP_CR |-> s_prompt)
    else $error("no lf");
  AST_PROMPT_SEQ: assert property (@(posedge sys_clk) disable iff (reset)
    st_q == smcp_pkg::SMCP_LF && tx_valid |=> st_q == smcp_pkg::SMCP_GT)
    else $error("no gt");
  AST_ABORT: assert property (@(posedge sys_clk) disable iff (reset)
    abort_q |-> st_q == smcp_pkg::SMCP_CR) else $error("abort path");
  AST_NO_ESC: assert property (@(posedge sys_clk) disable iff (reset)
    st_q == smcp_pkg::SMCP_OUT && job_host_display |-> !(tx_valid &&
    tx_data == smcp_pkg::CHR_ESC)) else $error("esc sent");
  AST_EXEC_GAP: assert property (@(posedge sys_clk) disable iff (reset)
    job_start |-> !cycle_running) else $error("exec in cycle");
  AST_ERR_HASH: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(st_q == smcp_pkg::SMCP_ERR) |-> $past(tx_valid) &&
    $past(tx_data) == smcp_pkg::CHR_HASH) else $error("no hash");
endmodule // smcp_top

// ---- hdl/smcp_pkg.sv ----
// Purpose: Shared constants for the serial monitor command port
// Assumes: Characters are 8-bit bytes from an external UART
// Notes: Buffer depth and margin are parameters of the top; the threshold is derived from them
package smcp_pkg;
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;
  localparam logic [7:0] CHR_PROMPT = 8'h3e;
  localparam logic [7:0] CHR_HASH = 8'h23;
  localparam logic [7:0] CHR_XON = 8'h11;
  localparam logic [7:0] CHR_XOFF = 8'h13;
  localparam logic [7:0] CHR_CTRL_C = 8'h03;
  localparam logic [7:0] CHR_ESC = 8'h1b;
  localparam logic [1:0] SERIAL_MODE_ACTIVE = 2'h1;
  localparam logic [1:0] SERIAL_MODE_STRAP = 2'h0;
  localparam int RX_DEPTH = 16;
  localparam int RX_MARGIN = 4;
  typedef enum logic [2:0] {
    SMCP_IDLE, SMCP_ECHO, SMCP_EXEC, SMCP_OUT, SMCP_ERR, SMCP_CR, SMCP_LF, SMCP_GT
  } smcp_state_t;
endpackage

// ---- hdl/smcp_mem.sv ----
// Purpose: Small receive buffer memory with registered read data
// Assumes: One write and one read port, same clock
// Notes: Read data appear one cycle after the read address
`timescale 1ns/100ps
module smcp_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic sys_clk,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data_q
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule // smcp_mem

// ---- test/smcp_term.sv ----
// Purpose: Terminal model at the far side of the port
// Assumes: One byte per clock pulse on each direction
// Notes: Idle data line shows the inverse of the last byte
`timescale 1ns/100ps
module smcp_term (
  // Clock
  input wire logic sys_clk,
  // Line handshake
  input wire logic rts,
  output logic cts,
  // Bytes to the port
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Bytes from the port
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Test controls
  input wire logic cts_hold,
  input wire logic tx_stall
);
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  assign cts = !cts_hold;
  assign tx_ready = !tx_stall;
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
  task automatic send(input logic [7:0] b, input bit rude);
    @(posedge sys_clk);
    while (!rts && !rude) begin
      @(posedge sys_clk);
    end
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
endmodule // smcp_term

// ---- test/test_smcp_top.sv ----
// Purpose: Self-checking bench for the monitor port
// Assumes: Executor side is modelled here
// Notes: Depth 16, margin 4
`timescale 1ns/100ps
module test_smcp_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic run_sel = 1'b1;
  logic [1:0] serial_mode_constant = 2'h1;
  logic mode_strap_pin = 1'b0;
  logic cycle_running = 1'b0;
  logic job_done = 1'b0;
  logic job_error = 1'b0;
  logic job_host_display = 1'b0;
  logic out_valid = 1'b0;
  logic [7:0] out_data = 8'h00;
  logic [7:0] err_valid_len = 8'h00;
  logic [7:0] err_data = 8'h00;
  logic active_mode, mode_strap_pin_suspend, rts, cts, rx_valid, tx_valid, tx_ready;
  logic job_char_valid, job_start, out_ready, job_abort, err_ready;
  logic [7:0] rx_data, tx_data, job_char;
  logic [7:0] xq[$];
  logic [7:0] eq[$];
  logic [7:0] jq[$];
  logic cts_hold = 1'b0;
  logic tx_stall = 1'b0;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int dmode = 0;
  int susp = 0;
  int txcyc = 0;
  int aborts = 0;
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  smcp_top uut (.sys_clk, .reset, .run_sel,
    .serial_mode_constant, .mode_strap_pin, .active_mode, .cycle_running,
    .mode_strap_pin_suspend, .rts, .cts, .rx_valid, .rx_data, .tx_valid, .tx_data,
    .tx_ready, .job_char_valid, .job_char, .job_start, .job_done, .job_error,
    .job_host_display, .out_valid, .out_data, .out_ready, .job_abort,
    .err_valid_len, .err_data, .err_ready);
  smcp_term term (.sys_clk, .rts, .cts, .rx_valid, .rx_data, .tx_valid,
    .tx_data, .tx_ready, .cts_hold, .tx_stall);
  // Executor model and monitors
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (out_valid && out_ready && xq.size() != 0) void'(xq.pop_front());
    if (err_ready && eq.size() != 0) void'(eq.pop_front());
    out_valid <= xq.size() != 0;
    out_data <= (xq.size() != 0) ? xq[0] : 8'hff;
    err_valid_len <= 8'(eq.size());
    err_data <= (eq.size() != 0) ? eq[0] : 8'hff;
    if (job_start) begin
      job_done <= (dmode == 1);
      job_error <= (dmode == 2);
    end
    if (rx_valid && cycle_running && mode_strap_pin_suspend) susp <= susp + 1;
    if ((tx_valid || job_start) && cycle_running) txcyc <= txcyc + 1;
    if (job_abort) aborts <= aborts + 1;
    if (job_char_valid) jq.push_back(job_char);
    if (cyc == 30000) begin
      mismatches++;
      results();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send_s(input string s, input bit rude);
    for (int i = 0; i < s.len(); i++) term.send(s[i], rude);
  endtask
  task automatic expect_tx(input string s);
    int n;
    n = 0;
    while (term.got.size() < s.len() && n < 800) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (4) @(posedge sys_clk);
    check("tx count", 8'(s.len()), 8'(term.got.size()));
    for (int i = 0; i < s.len() && i < term.got.size(); i++) check("tx byte", s[i], term.got[i]);
    term.got.delete();
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_mode();
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      run_sel <= i[0];
      serial_mode_constant <= i[2:1];
      mode_strap_pin <= i[3];
      @(posedge sys_clk);
      check("active_mode", 8'(!i[0] || i[2:1] == 1 || (i[2:1] == 0 && i[3])),
        8'(active_mode));
    end
    run_sel <= 1'b1;
    serial_mode_constant <= 2'h1;
    $display("t_mode done");
  endtask
  task automatic t_jobs();
    dmode = 1;
    send_s("AB\015", 0);
    expect_tx("AB\015\015\012>");
    check("job chars", 8'h03, 8'(jq.size()));
    check("job char first", 8'h41, (jq.size() > 0) ? jq[0] : 8'h00);
    check("job char last", smcp_pkg::CHR_CR, (jq.size() > 2) ? jq[2] : 8'h00);
    jq.delete();
    dmode = 2;
    eq.push_back(8'h45);
    eq.push_back(8'h46);
    send_s("X\015", 0);
    expect_tx("X\015#EF\015\012>");
    dmode = 0;
    job_done <= 1'b0;
    job_error <= 1'b0;
    job_host_display <= 1'b1;
    xq.push_back(smcp_pkg::CHR_ESC);
    xq.push_back(smcp_pkg::CHR_XOFF);
    xq.push_back(8'h44);
    send_s("Z\015", 0);
    for (int n = 0; n < 200 && xq.size() != 0; n++) @(posedge sys_clk);
    job_done <= 1'b1;
    expect_tx("Z\015D\015\012>");
    job_done <= 1'b0;
    job_host_display <= 1'b0;
    $display("t_jobs done");
  endtask
  task automatic t_cycle();
    cycle_running <= 1'b1;
    dmode = 1;
    repeat (2) @(posedge sys_clk);
    check("rts in cycle", 8'h00, 8'(rts));
    send_s("Q\015", 1);
    repeat (30) @(posedge sys_clk);
    check("suspends", 8'h02, 8'(susp));
    check("work in cycle", 8'h00, 8'(txcyc));
    cycle_running <= 1'b0;
    expect_tx("Q\015\015\012>");
    job_done <= 1'b0;
    dmode = 0;
    $display("t_cycle done");
  endtask
  task automatic t_fill();
    cts_hold <= 1'b1;
    send_s("abcdefghijkl", 0);
    repeat (4) @(posedge sys_clk);
    check("rts at fill", 8'h00, 8'(rts));
    check("tx without cts", 8'h00, 8'(term.got.size()));
    send_s("mnopq", 1);
    repeat (4) @(posedge sys_clk);
    check("rts when full", 8'h00, 8'(rts));
    cts_hold <= 1'b0;
    expect_tx("abcdefghijklmnop");
    tx_stall <= 1'b1;
    term.send(8'h41, 0);
    term.send(smcp_pkg::CHR_XOFF, 0);
    tx_stall <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check("tx after xoff", 8'h00, 8'(term.got.size()));
    term.send(smcp_pkg::CHR_XON, 0);
    expect_tx("A");
    $display("t_fill done");
  endtask
  task automatic t_abort();
    repeat (60) xq.push_back(8'h5a);
    send_s("W\015", 0);
    for (int n = 0; n < 300 && term.got.size() < 6; n++) @(posedge sys_clk);
    term.send(smcp_pkg::CHR_CTRL_C, 0);
    repeat (8) @(posedge sys_clk);
    check("abort pulses", 8'h01, 8'(aborts));
    check("prompt after abort", smcp_pkg::CHR_PROMPT, term.got[term.got.size() - 1]);
    xq.delete();
    do_reset();
    term.got.delete();
    $display("t_abort done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    t_mode();
    t_jobs();
    t_cycle();
    t_fill();
    t_abort();
    results();
  end
endmodule // test_smcp_top
